// ### icw_decoder_pkg.sv
// Package for the interrupt command word decoder: bit positions, encodings, types.
// Assumes an 8-bit host bus with one address line and a synchronous clock.
package icw_decoder_pkg;

    // First initialization word (address line low, marker bit 4 set)
    localparam int INIT_MARK_BIT     = 4;
    localparam int LEVEL_TRIG_BIT    = 3;
    localparam int CALL_INTERVAL_BIT = 2;
    localparam int SINGLE_DEV_BIT    = 1;
    localparam int MODE_NEEDED_BIT   = 0;

    // Mode word
    localparam int PROC_MODE_BIT     = 0;
    localparam int AUTO_END_BIT      = 1;
    localparam int MASTER_SEL_BIT    = 2;
    localparam int BUFFERED_BIT      = 3;
    localparam int SPECIAL_NEST_BIT  = 4;

    // End/rotate command
    localparam int ROTATE_BIT        = 7;
    localparam int SPECIFIC_BIT      = 6;
    localparam int END_SERVICE_BIT   = 5;
    localparam int OCW_MARK_BIT      = 3;

    // Read/poll command
    localparam int SPECIAL_EN_BIT    = 6;
    localparam int SPECIAL_MASK_BIT  = 5;
    localparam int POLL_BIT          = 2;
    localparam int READ_REG_BIT      = 1;
    localparam int REG_SELECT_BIT    = 0;

    localparam logic [7:0] ZERO_BYTE   = 8'h00;
    localparam logic [2:0] LOWEST_PRIO = 3'h7;

    typedef enum logic [1:0] {
        SEQ_OPER,
        SEQ_VECTOR,
        SEQ_CASCADE,
        SEQ_MODE
    } seq_state_t;

    // Host bus write or read request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       addr;
        logic [7:0] data;
    } bus_req_t;

    // Decoded configuration held after initialization
    typedef struct packed {
        logic       levelTrig;
        logic       callInterval;
        logic       singleDev;
        logic       modeNeeded;
        logic [7:0] callAddrLow;
        logic [7:0] vectorBase;
        logic [7:0] cascadeCfg;
        logic       procMode;
        logic       autoEnd;
        logic       masterSel;
        logic       buffered;
        logic       specialNest;
    } config_t;

endpackage

// ### interrupt_command_word_decoder.sv
// Decodes initialization and operational command words of an 8-input priority controller.
// Assumes host bus strobes synchronous to clk, one cycle per access; request lines are synchronous.
// Operation
// - Vectored-type mode: type is five programmed bits above the three-bit input number.
// - Vectored-type mode ignores call-address bits used only by call-vector mode.
// - Cascade word accepted only when first word selected cascade operation.
// - Master: each cascade bit flags a slave on the matching input.
// - Master when pin high unbuffered, or buffered with master bit set; else slave.
// - Slave identity is low three cascade bits, matching the master input wired.
// - Mode word accepted only when first word asked for it.
// - Processor-mode bit one selects vectored-type, zero selects call-vector mode.
// - Auto-end bit ends in-service automatically; otherwise software sends end command.
// - Master/slave bit used only in buffered mode, ignored otherwise.
// - Buffered mode turns the pin into transceiver enable; otherwise select input.
// - Special-nesting bit one selects special fully nested mode, master only advised.
// - After initialization the three operational words are accepted in any order.
// - Mask word write loads mask register; a read returns the mask.
// - Level field names input zero to seven, used only with specific-level bit.
// - End-of-service bit one runs the end form chosen by specific and rotate bits.
// - Rotate bit one performs rotation chosen by specific and end bits.
// - Read-register bit one selects in-service or request register for later reads.
// - Poll bit issues a poll and overrides a read-register request.
// - Special mask mode changes only when the enable bit in the word is one.
// - First word at address low with bit 4 set; bits 3..0 select modes.
// - First word clears in-service, mask and special mask, selects request reads.
// - Words told apart by address line, sequence position and fixed marker bits.
`timescale 1ns/1ps

module interrupt_command_word_decoder (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // Host bus
    input  wire icw_decoder_pkg::bus_req_t  busReq,
    output logic [7:0]                      readData,
    // Interrupt inputs and acknowledge
    input  wire logic [7:0]                 irqLines,
    input  wire logic                       intAck,
    output logic                            intReq,
    output logic [7:0]                      vectorOut,
    // Slave program / enable pin
    input  wire logic                       spEnIn,
    output logic                            spEnOut,
    output logic                            spEnOe,
    // Mode status
    output logic                            isMaster,
    output logic                            specialNestMode,
    output logic                            specialMaskMode,
    output logic                            autoEndMode,
    output logic [7:0]                      slavePresent,
    output logic [2:0]                      slaveIdentity
);

    typedef struct packed {
        icw_decoder_pkg::seq_state_t seq;
        icw_decoder_pkg::config_t    cfg;
        logic [7:0]                  maskReg;
        logic [7:0]                  inService;
        logic [7:0]                  reqReg;
        logic [7:0]                  prevLines;
        logic [2:0]                  lowestPrio;
        logic                        readIsr;
        logic                        pollPending;
        logic                        specialMask;
        logic                        rotateAuto;
        logic                        initDone;
        logic [7:0]                  readData;
        logic                        intReq;
        logic [7:0]                  vectorOut;
        logic                        spEnOut;
        logic                        spEnOe;
        logic                        isMaster;
    } state_t;

    state_t cur;
    state_t next_cur;

    // Highest-priority pending input, scanning from just above the lowest-priority slot
    function automatic logic [3:0] pick(input logic [7:0] pend, input logic [2:0] lowest);
        logic [3:0] res;
        logic [2:0] idx;
        res = 4'h0;
        for (int k = 7; k >= 0; k--) begin
            idx = lowest + 3'(k + 1);
            if (pend[idx]) begin
                res = {1'b1, idx};
            end
        end
        return res;
    endfunction

    logic       wrCtl;
    logic       wrData;
    logic [7:0] din;
    logic [7:0] edgeSeen;
    logic [7:0] pending;
    logic [3:0] winner;
    logic [3:0] topIsr;
    logic [2:0] lvl;
    logic [7:0] lvlBit;

    always_comb begin
        next_cur = cur;
        din      = busReq.data;
        // Address line distinguishes word groups
        wrCtl    = busReq.wr && !busReq.addr;
        wrData   = busReq.wr && busReq.addr;
        lvl      = din[2:0];
        lvlBit   = 8'h01 << lvl;

        // Request register: level mode follows lines, edge mode latches rising edges
        edgeSeen = irqLines & ~cur.prevLines;
        next_cur.prevLines = irqLines;
        if (cur.cfg.levelTrig) begin
            next_cur.reqReg = irqLines;
        end else begin
            next_cur.reqReg = (cur.reqReg | edgeSeen) & irqLines;
        end

        // Nesting: normal mode blocks equal or lower, special nesting blocks only lower
        topIsr   = pick(cur.inService, cur.lowestPrio);
        pending  = cur.reqReg & ~cur.maskReg;
        winner   = pick(pending, cur.lowestPrio);
        if (cur.initDone && winner[3]) begin
            if (topIsr[3] && !cur.specialMask) begin
                next_cur.intReq = (3'(winner[2:0] - cur.lowestPrio - 3'h1) <
                                   3'(topIsr[2:0] - cur.lowestPrio - 3'h1)) ||
                                  (cur.cfg.specialNest && winner[2:0] == topIsr[2:0]);
            end else begin
                next_cur.intReq = 1'b1;
            end
        end else begin
            next_cur.intReq = 1'b0;
        end

        // Acknowledge: load vector, set in-service unless auto end
        if (intAck && winner[3] && cur.initDone) begin
            if (cur.cfg.procMode) begin
                next_cur.vectorOut = {cur.cfg.vectorBase[7:3], winner[2:0]};
            end else if (cur.cfg.callInterval) begin
                next_cur.vectorOut = {cur.cfg.callAddrLow[7:5], winner[2:0], 2'b00};
            end else begin
                next_cur.vectorOut = {cur.cfg.callAddrLow[7:6], winner[2:0], 3'b000};
            end
            next_cur.reqReg[winner[2:0]] = cur.cfg.levelTrig ? cur.reqReg[winner[2:0]] : 1'b0;
            if (cur.cfg.autoEnd) begin
                if (cur.rotateAuto) begin
                    next_cur.lowestPrio = winner[2:0];
                end
            end else begin
                next_cur.inService[winner[2:0]] = 1'b1;
            end
        end

        // Master/slave role and pin use
        if (cur.cfg.buffered) begin
            next_cur.isMaster = cur.cfg.masterSel;
            next_cur.spEnOe   = 1'b0;
            next_cur.spEnOut  = !busReq.rd;
        end else begin
            next_cur.isMaster = spEnIn;
            next_cur.spEnOe   = 1'b1;
            next_cur.spEnOut  = 1'b1;
        end

        // Reads: poll overrides register read; data port reads the mask
        if (busReq.rd) begin
            if (cur.pollPending) begin
                next_cur.readData = {winner[3], 4'h0, winner[2:0]};
                next_cur.pollPending = 1'b0;
                if (winner[3]) begin
                    next_cur.inService[winner[2:0]] = 1'b1;
                    next_cur.reqReg[winner[2:0]] = 1'b0;
                end
            end else if (busReq.addr) begin
                next_cur.readData = cur.maskReg;
            end else begin
                next_cur.readData = cur.readIsr ? cur.inService : cur.reqReg;
            end
        end

        // First initialization word restarts the sequence
        if (wrCtl && din[icw_decoder_pkg::INIT_MARK_BIT]) begin
            next_cur.seq              = icw_decoder_pkg::SEQ_VECTOR;
            next_cur.initDone         = 1'b0;
            next_cur.cfg              = '0;
            next_cur.cfg.levelTrig    = din[icw_decoder_pkg::LEVEL_TRIG_BIT];
            next_cur.cfg.callInterval = din[icw_decoder_pkg::CALL_INTERVAL_BIT];
            next_cur.cfg.singleDev    = din[icw_decoder_pkg::SINGLE_DEV_BIT];
            next_cur.cfg.modeNeeded   = din[icw_decoder_pkg::MODE_NEEDED_BIT];
            next_cur.cfg.callAddrLow  = din;
            next_cur.inService        = icw_decoder_pkg::ZERO_BYTE;
            next_cur.maskReg          = icw_decoder_pkg::ZERO_BYTE;
            next_cur.reqReg           = icw_decoder_pkg::ZERO_BYTE;
            next_cur.prevLines        = irqLines;
            next_cur.specialMask      = 1'b0;
            next_cur.rotateAuto       = 1'b0;
            next_cur.readIsr          = 1'b0;
            next_cur.pollPending      = 1'b0;
            next_cur.lowestPrio       = icw_decoder_pkg::LOWEST_PRIO;
        end else begin
            case (cur.seq)
                icw_decoder_pkg::SEQ_VECTOR: begin
                    if (wrData) begin
                        next_cur.cfg.vectorBase = din;
                        // Cascade and mode words only when asked for
                        if (!cur.cfg.singleDev) begin
                            next_cur.seq = icw_decoder_pkg::SEQ_CASCADE;
                        end else if (cur.cfg.modeNeeded) begin
                            next_cur.seq = icw_decoder_pkg::SEQ_MODE;
                        end else begin
                            next_cur.seq = icw_decoder_pkg::SEQ_OPER;
                            next_cur.initDone = 1'b1;
                        end
                    end
                end
                icw_decoder_pkg::SEQ_CASCADE: begin
                    if (wrData) begin
                        next_cur.cfg.cascadeCfg = din;
                        if (cur.cfg.modeNeeded) begin
                            next_cur.seq = icw_decoder_pkg::SEQ_MODE;
                        end else begin
                            next_cur.seq = icw_decoder_pkg::SEQ_OPER;
                            next_cur.initDone = 1'b1;
                        end
                    end
                end
                icw_decoder_pkg::SEQ_MODE: begin
                    if (wrData) begin
                        next_cur.cfg.procMode    = din[icw_decoder_pkg::PROC_MODE_BIT];
                        next_cur.cfg.autoEnd     = din[icw_decoder_pkg::AUTO_END_BIT];
                        next_cur.cfg.masterSel   = din[icw_decoder_pkg::MASTER_SEL_BIT];
                        next_cur.cfg.buffered    = din[icw_decoder_pkg::BUFFERED_BIT];
                        next_cur.cfg.specialNest = din[icw_decoder_pkg::SPECIAL_NEST_BIT];
                        next_cur.seq             = icw_decoder_pkg::SEQ_OPER;
                        next_cur.initDone        = 1'b1;
                    end
                end
                icw_decoder_pkg::SEQ_OPER: begin
                    // Any order, any number of times
                    if (cur.initDone && wrData) begin
                        next_cur.maskReg = din;
                    end else if (cur.initDone && wrCtl && !din[icw_decoder_pkg::OCW_MARK_BIT]) begin
                        // End/rotate command
                        if (din[icw_decoder_pkg::END_SERVICE_BIT]) begin
                            if (din[icw_decoder_pkg::SPECIFIC_BIT]) begin
                                next_cur.inService = next_cur.inService & ~lvlBit;
                                if (din[icw_decoder_pkg::ROTATE_BIT]) begin
                                    next_cur.lowestPrio = lvl;
                                end
                            end else if (topIsr[3]) begin
                                next_cur.inService[topIsr[2:0]] = 1'b0;
                                if (din[icw_decoder_pkg::ROTATE_BIT]) begin
                                    next_cur.lowestPrio = topIsr[2:0];
                                end
                            end
                        end else if (din[icw_decoder_pkg::SPECIFIC_BIT]) begin
                            if (din[icw_decoder_pkg::ROTATE_BIT]) begin
                                next_cur.lowestPrio = lvl;
                            end
                        end else begin
                            next_cur.rotateAuto = din[icw_decoder_pkg::ROTATE_BIT];
                        end
                    end else if (cur.initDone && wrCtl) begin
                        // Read/poll command
                        if (din[icw_decoder_pkg::POLL_BIT]) begin
                            next_cur.pollPending = 1'b1;
                        end else if (din[icw_decoder_pkg::READ_REG_BIT]) begin
                            next_cur.readIsr = din[icw_decoder_pkg::REG_SELECT_BIT];
                        end
                        if (din[icw_decoder_pkg::SPECIAL_EN_BIT]) begin
                            next_cur.specialMask = din[icw_decoder_pkg::SPECIAL_MASK_BIT];
                        end
                    end
                end
                default: begin
                    next_cur.seq = icw_decoder_pkg::SEQ_OPER;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur         <= '0;
            cur.seq     <= icw_decoder_pkg::SEQ_OPER;
            cur.spEnOut <= 1'b1;
            cur.spEnOe  <= 1'b1;
            cur.lowestPrio <= icw_decoder_pkg::LOWEST_PRIO;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from the state register
    assign readData        = cur.readData;
    assign intReq          = cur.intReq;
    assign vectorOut       = cur.vectorOut;
    assign spEnOut         = cur.spEnOut;
    assign spEnOe          = cur.spEnOe;
    assign isMaster        = cur.isMaster;
    assign specialNestMode = cur.cfg.specialNest;
    assign specialMaskMode = cur.specialMask;
    assign autoEndMode     = cur.cfg.autoEnd;
    assign slavePresent    = cur.cfg.cascadeCfg;
    assign slaveIdentity   = cur.cfg.cascadeCfg[2:0];

endmodule

// ### icw_decoder_asserts.sv
// Checker on the decoder's ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module icw_decoder_asserts (
    // Clock and reset
    input wire logic                      clk,
    input wire logic                      rst,
    // Host bus and status
    input wire icw_decoder_pkg::bus_req_t busReq,
    input wire logic [7:0]                readData,
    input wire logic                      intAck,
    input wire logic [7:0]                vectorOut,
    input wire logic                      specialNestMode,
    input wire logic                      specialMaskMode,
    input wire logic                      autoEndMode,
    input wire logic [7:0]                slavePresent,
    input wire logic [2:0]                slaveIdentity
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    wire initWr = busReq.wr && !busReq.addr && busReq.data[4];
    wire pollWr = busReq.wr && !busReq.addr && busReq.data[4:2] == 3'b011;
    sequence s_poll_cmd;
        pollWr;
    endsequence
    sequence s_poll_read;
        s_poll_cmd ##[1:2] busReq.rd;
    endsequence
    property p_read_hold;
        !busReq.rd |=> $stable(readData);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data moved without a read");
    property p_vec_hold;
        !intAck && !$past(intAck) && !initWr |=> $stable(vectorOut);
    endproperty
    a_vec_hold: assert property (p_vec_hold) else $error("vector moved without acknowledge");
    property p_init_smm;
        initWr |=> !specialMaskMode;
    endproperty
    a_init_smm: assert property (p_init_smm) else $error("special mask kept over first word");
    property p_no_mode;
        initWr && !busReq.data[0] |=> !autoEndMode && !specialNestMode;
    endproperty
    a_no_mode: assert property (p_no_mode) else $error("mode bits kept without mode word");
    property p_smm_keep;
        busReq.wr && !busReq.addr && busReq.data[4:3] == 2'b01 && !busReq.data[6] |=> $stable(specialMaskMode);
    endproperty
    a_smm_keep: assert property (p_smm_keep) else $error("special mask changed while disabled");
    property p_casc_keep;
        !(busReq.wr && busReq.addr) && !initWr |=> $stable({slavePresent, slaveIdentity});
    endproperty
    a_casc_keep: assert property (p_casc_keep) else $error("cascade word changed unwritten");
    property p_mode_keep;
        !busReq.wr |=> $stable({autoEndMode, specialNestMode, specialMaskMode});
    endproperty
    a_mode_keep: assert property (p_mode_keep) else $error("mode changed without a write");
    property p_poll_fmt;
        s_poll_read |=> readData[6:3] == 4'h0;
    endproperty
    a_poll_fmt: assert property (p_poll_fmt) else $error("poll answer malformed");
endmodule
bind interrupt_command_word_decoder icw_decoder_asserts i_icw_decoder_asserts (
    .clk(clk), .rst(rst), .busReq(busReq), .readData(readData), .intAck(intAck),
    .vectorOut(vectorOut), .specialNestMode(specialNestMode), .specialMaskMode(specialMaskMode),
    .autoEndMode(autoEndMode), .slavePresent(slavePresent), .slaveIdentity(slaveIdentity));

// ### host_bus_model.sv
// Host processor model: word writes and reads on the decoder bus.
// Assumes the bench clock; one access at a time, never before reset ends.
`timescale 1ns/1ps
module host_bus_model (
    // Clock
    input  wire logic                 clk,
    // Host bus
    output icw_decoder_pkg::bus_req_t busReq,
    input  wire logic [7:0]           readData
);
    initial busReq = '0;
    task automatic write_word(input logic addr, input logic [7:0] data);
        @(posedge clk);
        #1;
        busReq = '{wr: 1'b1, rd: 1'b0, addr: addr, data: data};
        @(posedge clk);
        #1;
        busReq.wr = 1'b0;
        // Released bus shows junk, not the old byte
        busReq.data = ~data;
    endtask
    task automatic read_word(input logic addr, output logic [7:0] data);
        @(posedge clk);
        #1;
        busReq = '{wr: 1'b0, rd: 1'b1, addr: addr, data: 8'hA5};
        @(posedge clk);
        #1;
        busReq.rd = 1'b0;
        data = readData;
    endtask
endmodule

// ### interrupt_command_word_decoder_tb_top.sv
// Self-checking bench for the command word decoder.
// Assumes the host model drives the bus; bench drives requests and the pin.
`timescale 1ns/1ps
module interrupt_command_word_decoder_tb_top;
    logic                      clk = 1'b0;
    logic                      rst = 1'b1;
    logic [7:0]                irqLines = 8'h00;
    logic                      intAck = 1'b0;
    logic                      spEnDrv = 1'b1;
    icw_decoder_pkg::bus_req_t busReq;
    logic [7:0]                readData, vectorOut, slavePresent, rd;
    logic                      intReq, spEnOut, spEnOe, isMaster, specialNestMode, specialMaskMode, autoEndMode;
    logic [2:0]                slaveIdentity;
    int                        mismatches = 0;
    int                        nChecks = 0;
    int                        cycles = 0;
    wire                       spEnPin = spEnOe ? spEnDrv : spEnOut;

    always #2 clk = ~clk;

    interrupt_command_word_decoder i_interrupt_command_word_decoder (.clk(clk), .rst(rst), .busReq(busReq),
        .readData(readData), .irqLines(irqLines), .intAck(intAck), .intReq(intReq), .vectorOut(vectorOut),
        .spEnIn(spEnPin), .spEnOut(spEnOut), .spEnOe(spEnOe), .isMaster(isMaster),
        .specialNestMode(specialNestMode), .specialMaskMode(specialMaskMode), .autoEndMode(autoEndMode),
        .slavePresent(slavePresent), .slaveIdentity(slaveIdentity));
    host_bus_model i_host_bus_model (.clk(clk), .busReq(busReq), .readData(readData));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        nChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic a, input logic [7:0] d);
        i_host_bus_model.write_word(a, d);
    endtask
    task automatic rdw(input logic a, input logic [7:0] e, input string what);
        i_host_bus_model.read_word(a, rd);
        chk(what, e, rd);
    endtask
    // Later words only as the first word asks for them
    task automatic init_seq(input logic [7:0] w1, input logic [7:0] w2, input logic [7:0] w3, input logic [7:0] w4);
        wr(1'b0, w1);
        wr(1'b1, w2);
        if (!w1[1]) wr(1'b1, w3);
        if (w1[0]) wr(1'b1, w4);
    endtask
    task automatic t_sequence;
        init_seq(8'h1D, 8'h02, 8'h80, 8'h10);
        chk("nest", 8'h01, {7'h0, specialNestMode});
        chk("slaves", 8'h80, slavePresent);
        chk("autoEnd", 8'h00, {7'h0, autoEndMode});
        wr(1'b1, 8'h5A);
        rdw(1'b1, 8'h5A, "mask");
        init_seq(8'h13, 8'h02, 8'h00, 8'h02);
        chk("autoEnd", 8'h01, {7'h0, autoEndMode});
        rdw(1'b1, 8'h00, "mask");
        init_seq(8'h1A, 8'h02, 8'h00, 8'h00);
        chk("autoEnd", 8'h00, {7'h0, autoEndMode});
        wr(1'b1, 8'h33);
        rdw(1'b1, 8'h33, "mask");
        $display("t_sequence done");
    endtask
    task automatic role_case(input logic pin, input logic [7:0] mode, input logic master);
        spEnDrv = pin;
        init_seq(8'h19, 8'h02, 8'h06, mode);
        // Role and pin use follow the mode word one cycle later
        @(posedge clk);
        #1;
        chk("master", {7'h0, master}, {7'h0, isMaster});
        chk("pinDrive", {7'h0, !mode[3]}, {7'h0, spEnOe});
        chk("identity", 8'h06, {5'h0, slaveIdentity});
        rdw(1'b1, 8'h00, "mask");
        chk("pinOut", {7'h0, !mode[3]}, {7'h0, spEnOut});
    endtask
    task automatic t_role;
        role_case(1'b1, 8'h00, 1'b1);
        role_case(1'b0, 8'h04, 1'b0);
        role_case(1'b0, 8'h0C, 1'b1);
        role_case(1'b1, 8'h08, 1'b0);
        $display("t_role done");
    endtask
    task automatic t_special_mask;
        logic [7:0] w [5] = '{8'h68, 8'h28, 8'h48, 8'h08, 8'h68};
        logic       e [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        init_seq(8'h1A, 8'h02, 8'h00, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(1'b0, w[i]);
            chk("specialMask", {7'h0, e[i]}, {7'h0, specialMaskMode});
        end
        wr(1'b0, 8'h1A);
        chk("specialMask", 8'h00, {7'h0, specialMaskMode});
        $display("t_special_mask done");
    endtask
    task automatic t_status;
        irqLines = 8'h24;
        init_seq(8'h1A, 8'h02, 8'h00, 8'h00);
        wr(1'b0, 8'h0A);
        rdw(1'b0, 8'h24, "request");
        wr(1'b0, 8'h0B);
        rdw(1'b0, 8'h00, "inService");
        wr(1'b0, 8'h0E);
        rdw(1'b0, 8'h82, "poll");
        wr(1'b0, 8'h00);
        rdw(1'b0, 8'h04, "inService");
        wr(1'b0, 8'h20);
        rdw(1'b0, 8'h00, "inService");
        wr(1'b0, 8'hC2);
        wr(1'b0, 8'h0C);
        rdw(1'b0, 8'h85, "poll");
        wr(1'b0, 8'h65);
        rdw(1'b0, 8'h00, "inService");
        $display("t_status done");
    endtask
    task automatic vec_case(input logic [7:0] w1, input logic [7:0] w2, input logic [7:0] w4, input logic [7:0] e);
        init_seq(w1, w2, 8'h00, w4);
        repeat (3) @(posedge clk);
        #1;
        chk("intReq", 8'h01, {7'h0, intReq});
        intAck = 1'b1;
        @(posedge clk);
        #1;
        intAck = 1'b0;
        @(posedge clk);
        #1;
        chk("vector", e, vectorOut);
    endtask
    task automatic t_vector;
        // Vectored type with call bits set in the first word: they must not leak in
        vec_case(8'hFB, 8'h4F, 8'h01, 8'h4A);
        // Call-vector form, 4-byte interval: three address bits above the input number
        vec_case(8'hBE, 8'h4F, 8'h00, 8'hA8);
        $display("t_vector done");
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        t_sequence();
        t_role();
        t_special_mask();
        t_status();
        t_vector();
        print_verdict();
    end
endmodule
